// *** design/ifrps_pkg.sv ***
// Constants for the image format, test pattern, mirror and region stage.
// Assumes a single clock and the plain register port of the top module.
package ifrps_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_FORMAT     = 8'h04;
	localparam logic [7:0] ADDR_ADC_DEPTH  = 8'h08;
	localparam logic [7:0] ADDR_PAT_SOURCE = 8'h0C;
	localparam logic [7:0] ADDR_PAT_CHOICE = 8'h10;
	localparam logic [7:0] ADDR_ROI_LEFT   = 8'h14;
	localparam logic [7:0] ADDR_ROI_TOP    = 8'h18;
	localparam logic [7:0] ADDR_ROI_WIDTH  = 8'h1C;
	localparam logic [7:0] ADDR_ROI_HEIGHT = 8'h20;
	localparam logic [7:0] ADDR_HLIMIT     = 8'h24;
	localparam logic [7:0] ADDR_VLIMIT     = 8'h28;
	localparam logic [7:0] ADDR_WIDTH_MAX  = 8'h2C;
	localparam logic [7:0] ADDR_HEIGHT_MAX = 8'h30;
	localparam logic [7:0] ADDR_STATUS     = 8'h34;
	localparam logic [7:0] ADDR_BLACK      = 8'h38;
	// Control field positions
	localparam int CTRL_ACQ_BIT  = 0;
	localparam int CTRL_MIRH_BIT = 1;
	localparam int CTRL_MIRV_BIT = 2;
	// Status field positions
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_SENS_BIT   = 1;
	localparam int STAT_PIPE_BIT   = 2;
	localparam int STAT_MOSAIC_LSB = 4;
	// Reset values
	localparam logic [2:0]  CTRL_RST  = 3'h0;
	localparam logic [15:0] BLACK_RST = 16'h0000;
	typedef enum logic [1:0] {
		FMT_MOSAIC8        = 2'h0,
		FMT_MOSAIC16       = 2'h1,
		CHROMA_HALF_FORMAT = 2'h2,
		CHROMA_QUARTER_FORMAT = 2'h3
	} ifrps_fmt_t;
	typedef enum logic [1:0] {
		ADC_10 = 2'h0,
		ADC_12 = 2'h1,
		ADC_14 = 2'h2
	} ifrps_adc_t;
	typedef enum logic [1:0] {
		MOSAIC_RED_FIRST  = 2'h0,
		MOSAIC_GREEN_RED  = 2'h1,
		MOSAIC_GREEN_BLUE = 2'h2,
		MOSAIC_BLUE_FIRST = 2'h3
	} ifrps_mosaic_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CAPT = 3'b010,
		ST_READ = 3'b100
	} ifrps_state_t;
	// Left-justify shifts into a 16-bit word
	localparam int LJ_SHIFT_10 = 6;
	localparam int LJ_SHIFT_12 = 4;
	localparam int LJ_SHIFT_14 = 2;
	localparam logic [15:0] MASK_12 = 16'hFFF0;
	// Colour conversion, coefficients scaled by 256
	localparam int Y_R  = 77;
	localparam int Y_G  = 150;
	localparam int Y_B  = 29;
	localparam int CB_R = -43;
	localparam int CB_G = -85;
	localparam int CB_B = 128;
	localparam int CR_R = 128;
	localparam int CR_G = -107;
	localparam int CR_B = -21;
	localparam int ROUND_HALF = 128;
	localparam int CHROMA_OFS = 32768;
endpackage : ifrps_pkg

// *** design/ifrps_top.sv ***
// Format, test pattern, mirror and region-of-interest stage of a pixel pipeline.
// Assumes sensor pixels and register port share clk_sys; the sink always accepts output.
// Behaviour
// - Half chroma format: every luma, one Cb/Cr pair per two pixels, all lines.
// - Quarter chroma format: every luma, one Cb/Cr pair per four pixels, all lines.
// - 8-bit luma and chroma span 0..255 for RGB inputs within 0..255.
// - Narrower output than converter: drop lowest converter bits.
// - Wider output than converter: pad lowest positions, receiver may ignore.
// - Samples left-justified in 16 bits; 12-bit gives mask FFF0.
// - 10, 12, 14 bit tops are 65472, 65520, 65532.
// - Two pattern generators, imager and pipeline entry, addressed by source select.
// - Pattern off disables only the currently selected generator.
// - Pipeline ramp adds one per pixel, wraps to zero after 255.
// - Both generators on: pipeline pattern replaces imager pattern.
// - Patterns skip black level but still pass format conversion.
// - Real imager data only when both generators are off.
// - Output only pixels inside the left, top, width, height rectangle.
// - Width maximum is horizontal limit minus left offset.
// - Height maximum is vertical limit minus top offset.
// - Horizontal mirror reverses pixel order, crop applies afterwards.
// - Vertical mirror reverses line order, crop applies afterwards.
// - Mirroring changes reported mosaic order: horizontal green-red, vertical green-blue.
//
// Strobed register access and the address map were decided locally.
module ifrps_top #(
	parameter int MAX_W = 16,  // horizontal_limit in pixels
	parameter int MAX_H = 16,  // vertical_limit in lines
	parameter int ADC_W = 14   // converter sample width
) (
	input  wire logic               clk_sys,          // 25 MHz system clock
	input  wire logic               reset_n,          // asynchronous reset, active low
	input  wire logic [7:0]         reg_addr,         // register byte address
	input  wire logic [31:0]        reg_wdata,        // register write data
	input  wire logic               reg_wr,           // write strobe
	input  wire logic               reg_rd,           // read strobe
	output logic      [31:0]        reg_rdata,        // read data, cycle after strobe
	input  wire logic               in_valid,         // sensor pixel valid
	input  wire logic               in_sof,           // first pixel of frame
	input  wire logic [ADC_W-1:0]   in_sample,        // converter sample, right aligned
	input  wire logic [23:0]        in_rgb,           // interpolated colour {R,G,B}
	output logic                    out_valid,        // output pixel valid
	output logic                    out_sof,          // first output pixel
	output logic                    out_eol,          // last pixel of a line
	output logic                    out_eof,          // last pixel of frame
	output logic      [15:0]        out_data,         // formatted pixel word
	output logic                    out_chroma_valid, // upper byte carries chroma
	output logic                    busy              // capturing or reading out
);
	localparam int XW = $clog2(MAX_W + 1);
	localparam int YW = $clog2(MAX_H + 1);
	localparam int AW = $clog2(MAX_W * MAX_H);
	localparam logic [XW-1:0] HLIM = XW'(MAX_W);
	localparam logic [YW-1:0] VLIM = YW'(MAX_H);

	if (ADC_W < 14 || ADC_W > 16 || MAX_W < 4 || MAX_H < 2 || MAX_W > 4096 || MAX_H > 4096)
	begin : g_bad_param
		$error("ifrps_top: unsupported geometry or sample width");
	end

	// Register state
	logic [2:0]                ctrl_q, ctrl_d;
	ifrps_pkg::ifrps_fmt_t     fmt_q, fmt_d;
	ifrps_pkg::ifrps_adc_t     adc_q, adc_d;
	logic                      psel_q, psel_d;
	logic                      sens_q, sens_d;
	logic                      pipe_q, pipe_d;
	logic [XW-1:0]             left_q, left_d, width_q, width_d;
	logic [YW-1:0]             top_q, top_d, height_q, height_d;
	logic [15:0]               black_q, black_d;
	logic [31:0]               rdata_d;
	ifrps_pkg::ifrps_mosaic_t  mosaic;
	logic [XW-1:0]             eff_left, wmax, eff_w;
	logic [YW-1:0]             eff_top, hmax, eff_h;
	logic                      mir_h, mir_v;

	// Pipeline state
	ifrps_pkg::ifrps_state_t   st_q, st_d;
	logic [XW-1:0]             cx_q, cx_d, ox_q, ox_d;
	logic [YW-1:0]             cy_q, cy_d, oy_q, oy_d;
	logic [7:0]                ramp_q, ramp_d;
	logic                      cap_we, rd_go, cap_last;
	logic [AW-1:0]             wr_addr, rd_addr;
	logic [39:0]               wr_word, mem_q;
	logic [39:0]               frame_mem [MAX_W*MAX_H];
	logic [ADC_W-1:0]          blk_sample;
	logic [15:0]               lj;
	logic [7:0]                pat_val;
	logic [XW-1:0]             sx;
	logic [YW-1:0]             sy;
	logic                      s1_v_q, s1_v_d, s1_sof_q, s1_sof_d, s1_eol_q, s1_eol_d, s1_eof_q, s1_eof_d;
	logic [1:0]                s1_pos_q, s1_pos_d;
	logic [7:0]                cr_hold_q, cr_hold_d;
	logic                      ov_d, osof_d, oeol_d, oeof_d, ochr_d;
	logic [15:0]               odata_d;
	int                        y_acc, cb_acc, cr_acc;
	logic [7:0]                y_val, cb_val, cr_val;
	logic [XW-1:0]             line_cnt_q, line_cnt_d;

	function automatic logic [7:0] sat8(input int v);
		int s;
		s = v >>> 8;
		if (s > 255)
			return 8'hFF;
		else if (s < 0)
			return 8'h00;
		return 8'(s);
	endfunction : sat8

	assign mir_h    = ctrl_q[ifrps_pkg::CTRL_MIRH_BIT];
	assign mir_v    = ctrl_q[ifrps_pkg::CTRL_MIRV_BIT];
	assign busy     = (st_q != ifrps_pkg::ST_IDLE);

	// Region limits, clamped so a stale width cannot overrun the frame
	always_comb
	begin
		eff_left = (left_q >= HLIM) ? HLIM - XW'(1) : left_q;
		eff_top  = (top_q >= VLIM) ? VLIM - YW'(1) : top_q;
		wmax     = HLIM - eff_left;
		hmax     = VLIM - eff_top;
		eff_w    = (width_q == '0) ? XW'(1) : ((width_q > wmax) ? wmax : width_q);
		eff_h    = (height_q == '0) ? YW'(1) : ((height_q > hmax) ? hmax : height_q);
		unique case ({mir_v, mir_h})
			2'b01:   mosaic = ifrps_pkg::MOSAIC_GREEN_RED;
			2'b10:   mosaic = ifrps_pkg::MOSAIC_GREEN_BLUE;
			2'b11:   mosaic = ifrps_pkg::MOSAIC_BLUE_FIRST;
			default: mosaic = ifrps_pkg::MOSAIC_RED_FIRST;
		endcase
	end

	// Register writes and reads
	always_comb
	begin
		ctrl_d   = ctrl_q;
		fmt_d    = fmt_q;
		adc_d    = adc_q;
		psel_d   = psel_q;
		sens_d   = sens_q;
		pipe_d   = pipe_q;
		left_d   = left_q;
		top_d    = top_q;
		width_d  = width_q;
		height_d = height_q;
		black_d  = black_q;
		rdata_d  = 32'h0000_0000;
		if (reg_wr)
		begin
			unique case (reg_addr)
				ifrps_pkg::ADDR_CTRL:       ctrl_d = reg_wdata[2:0];
				ifrps_pkg::ADDR_FORMAT:     fmt_d = ifrps_pkg::ifrps_fmt_t'(reg_wdata[1:0]);
				ifrps_pkg::ADDR_ADC_DEPTH:
					// Depth only moves between frames; mid-frame change would mix shifts
					if (!busy && reg_wdata[1:0] != 2'h3)
						adc_d = ifrps_pkg::ifrps_adc_t'(reg_wdata[1:0]);
				ifrps_pkg::ADDR_PAT_SOURCE: psel_d = reg_wdata[0];
				ifrps_pkg::ADDR_PAT_CHOICE:
					if (psel_q)
						pipe_d = reg_wdata[0];
					else
						sens_d = reg_wdata[0];
				// Saturate before narrowing, so large values clamp instead of wrapping
				ifrps_pkg::ADDR_ROI_LEFT:   left_d = (reg_wdata[15:0] > 16'(MAX_W)) ? HLIM : XW'(reg_wdata[15:0]);
				ifrps_pkg::ADDR_ROI_TOP:    top_d = (reg_wdata[15:0] > 16'(MAX_H)) ? VLIM : YW'(reg_wdata[15:0]);
				ifrps_pkg::ADDR_ROI_WIDTH:  width_d = (reg_wdata[15:0] > 16'(MAX_W)) ? HLIM : XW'(reg_wdata[15:0]);
				ifrps_pkg::ADDR_ROI_HEIGHT: height_d = (reg_wdata[15:0] > 16'(MAX_H)) ? VLIM : YW'(reg_wdata[15:0]);
				ifrps_pkg::ADDR_BLACK:      black_d = reg_wdata[15:0];
				default:                    ;
			endcase
		end
		if (reg_rd)
		begin
			unique case (reg_addr)
				ifrps_pkg::ADDR_CTRL:       rdata_d = {29'h0, ctrl_q};
				ifrps_pkg::ADDR_FORMAT:     rdata_d = {30'h0, fmt_q};
				ifrps_pkg::ADDR_ADC_DEPTH:  rdata_d = {30'h0, adc_q};
				ifrps_pkg::ADDR_PAT_SOURCE: rdata_d = {31'h0, psel_q};
				ifrps_pkg::ADDR_PAT_CHOICE: rdata_d = {31'h0, psel_q ? pipe_q : sens_q};
				ifrps_pkg::ADDR_ROI_LEFT:   rdata_d = 32'(eff_left);
				ifrps_pkg::ADDR_ROI_TOP:    rdata_d = 32'(eff_top);
				ifrps_pkg::ADDR_ROI_WIDTH:  rdata_d = 32'(eff_w);
				ifrps_pkg::ADDR_ROI_HEIGHT: rdata_d = 32'(eff_h);
				ifrps_pkg::ADDR_HLIMIT:     rdata_d = 32'(HLIM);
				ifrps_pkg::ADDR_VLIMIT:     rdata_d = 32'(VLIM);
				ifrps_pkg::ADDR_WIDTH_MAX:  rdata_d = 32'(wmax);
				ifrps_pkg::ADDR_HEIGHT_MAX: rdata_d = 32'(hmax);
				ifrps_pkg::ADDR_STATUS:
					rdata_d = {26'h0, mosaic, 1'b0, pipe_q, sens_q, busy};
				ifrps_pkg::ADDR_BLACK:      rdata_d = {16'h0, black_q};
				default:                    rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl_q    <= ifrps_pkg::CTRL_RST;
			fmt_q     <= ifrps_pkg::FMT_MOSAIC8;
			adc_q     <= ifrps_pkg::ADC_12;
			psel_q    <= 1'b0;
			sens_q    <= 1'b0;
			pipe_q    <= 1'b0;
			left_q    <= '0;
			top_q     <= '0;
			width_q   <= HLIM;
			height_q  <= VLIM;
			black_q   <= ifrps_pkg::BLACK_RST;
			reg_rdata <= 32'h0000_0000;
		end
		else
		begin
			ctrl_q    <= ctrl_d;
			fmt_q     <= fmt_d;
			adc_q     <= adc_d;
			psel_q    <= psel_d;
			sens_q    <= sens_d;
			pipe_q    <= pipe_d;
			left_q    <= left_d;
			top_q     <= top_d;
			width_q   <= width_d;
			height_q  <= height_d;
			black_q   <= black_d;
			reg_rdata <= rdata_d;
		end
	end

	// Capture path: black level on real data only, then pattern override
	always_comb
	begin
		blk_sample = (ADC_W'(black_q) >= in_sample) ? '0 : in_sample - ADC_W'(black_q);
		unique case (adc_q)
			ifrps_pkg::ADC_10: lj = 16'(32'(blk_sample) << ifrps_pkg::LJ_SHIFT_10);
			ifrps_pkg::ADC_14: lj = 16'(32'(blk_sample) << ifrps_pkg::LJ_SHIFT_14);
			default:           lj = 16'(32'(blk_sample) << ifrps_pkg::LJ_SHIFT_12);
		endcase
		pat_val = 8'(cx_q) ^ 8'(cy_q);
		if (pipe_q)
			wr_word = {ramp_q, 8'h00, {3{ramp_q}}};
		else if (sens_q)
			wr_word = {pat_val, 8'h00, {3{pat_val}}};
		else
			wr_word = {lj, in_rgb};
		wr_addr = AW'(int'(cy_q) * MAX_W + int'(cx_q));
	end

	// Readout address: mirror first, then crop
	always_comb
	begin
		sx = eff_left + ox_q;
		sy = eff_top + oy_q;
		if (mir_h)
			sx = HLIM - XW'(1) - sx;
		if (mir_v)
			sy = VLIM - YW'(1) - sy;
		rd_addr = AW'(int'(sy) * MAX_W + int'(sx));
	end

	// Frame sequencer
	always_comb
	begin
		st_d     = st_q;
		cx_d     = cx_q;
		cy_d     = cy_q;
		ox_d     = ox_q;
		oy_d     = oy_q;
		ramp_d   = ramp_q;
		cap_we   = 1'b0;
		rd_go    = 1'b0;
		cap_last = (cx_q == HLIM - XW'(1)) && (cy_q == VLIM - YW'(1));
		s1_sof_d = 1'b0;
		s1_eol_d = 1'b0;
		s1_eof_d = 1'b0;
		unique case (st_q)
			ifrps_pkg::ST_IDLE:
				if (ctrl_q[ifrps_pkg::CTRL_ACQ_BIT] && in_valid && in_sof)
				begin
					cap_we = 1'b1;
					cx_d   = XW'(1);
					ramp_d = ramp_q + 8'h01;
					st_d   = ifrps_pkg::ST_CAPT;
				end
			ifrps_pkg::ST_CAPT:
				if (in_valid)
				begin
					cap_we = 1'b1;
					ramp_d = ramp_q + 8'h01;
					cx_d   = cx_q + XW'(1);
					if (cx_q == HLIM - XW'(1))
					begin
						cx_d = '0;
						cy_d = cy_q + YW'(1);
					end
					if (cap_last)
					begin
						cy_d   = '0;
						ramp_d = 8'h00;
						st_d   = ifrps_pkg::ST_READ;
					end
				end
			ifrps_pkg::ST_READ:
			begin
				rd_go    = 1'b1;
				s1_sof_d = (ox_q == '0) && (oy_q == '0);
				s1_eol_d = (ox_q >= eff_w - XW'(1));
				s1_eof_d = s1_eol_d && (oy_q >= eff_h - YW'(1));
				ox_d     = ox_q + XW'(1);
				if (s1_eol_d)
				begin
					ox_d = '0;
					oy_d = oy_q + YW'(1);
				end
				if (s1_eof_d)
				begin
					oy_d = '0;
					st_d = ifrps_pkg::ST_IDLE;
				end
			end
			default:
				st_d = ifrps_pkg::ST_IDLE;
		endcase
		s1_v_d   = rd_go;
		s1_pos_d = ox_q[1:0];
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_q     <= ifrps_pkg::ST_IDLE;
			cx_q     <= '0;
			cy_q     <= '0;
			ox_q     <= '0;
			oy_q     <= '0;
			ramp_q   <= 8'h00;
			s1_v_q   <= 1'b0;
			s1_sof_q <= 1'b0;
			s1_eol_q <= 1'b0;
			s1_eof_q <= 1'b0;
			s1_pos_q <= 2'h0;
		end
		else
		begin
			st_q     <= st_d;
			cx_q     <= cx_d;
			cy_q     <= cy_d;
			ox_q     <= ox_d;
			oy_q     <= oy_d;
			ramp_q   <= ramp_d;
			s1_v_q   <= s1_v_d;
			s1_sof_q <= s1_sof_d;
			s1_eol_q <= s1_eol_d;
			s1_eof_q <= s1_eof_d;
			s1_pos_q <= s1_pos_d;
		end
	end

	// Whole frame is stored because vertical mirroring needs the last line first
	always_ff @(posedge clk_sys)
	begin
		if (cap_we)
			frame_mem[wr_addr] <= wr_word;
		mem_q <= frame_mem[rd_addr];
	end

	// Output formatting
	always_comb
	begin
		y_acc  = ifrps_pkg::Y_R * int'(mem_q[23:16]) + ifrps_pkg::Y_G * int'(mem_q[15:8])
			+ ifrps_pkg::Y_B * int'(mem_q[7:0]) + ifrps_pkg::ROUND_HALF;
		cb_acc = ifrps_pkg::CB_R * int'(mem_q[23:16]) + ifrps_pkg::CB_G * int'(mem_q[15:8])
			+ ifrps_pkg::CB_B * int'(mem_q[7:0]) + ifrps_pkg::CHROMA_OFS + ifrps_pkg::ROUND_HALF;
		cr_acc = ifrps_pkg::CR_R * int'(mem_q[23:16]) + ifrps_pkg::CR_G * int'(mem_q[15:8])
			+ ifrps_pkg::CR_B * int'(mem_q[7:0]) + ifrps_pkg::CHROMA_OFS + ifrps_pkg::ROUND_HALF;
		y_val  = sat8(y_acc);
		cb_val = sat8(cb_acc);
		cr_val = sat8(cr_acc);
		// Chroma of a group comes from its first pixel
		// Every even position opens a half-format pair; quarter groups reuse only position 0
		cr_hold_d = (s1_v_q && !s1_pos_q[0]) ? cr_val : cr_hold_q;
		ov_d    = s1_v_q;
		osof_d  = s1_sof_q;
		oeol_d  = s1_eol_q;
		oeof_d  = s1_eof_q;
		ochr_d  = 1'b0;
		odata_d = 16'h0000;
		if (s1_v_q)
		begin
			unique case (fmt_q)
				ifrps_pkg::FMT_MOSAIC8:  odata_d = {8'h00, mem_q[39:32]};
				ifrps_pkg::FMT_MOSAIC16: odata_d = mem_q[39:24];
				ifrps_pkg::CHROMA_HALF_FORMAT:
				begin
					ochr_d  = 1'b1;
					odata_d = {s1_pos_q[0] ? cr_hold_q : cb_val, y_val};
				end
				ifrps_pkg::CHROMA_QUARTER_FORMAT:
				begin
					ochr_d  = (s1_pos_q[1] == 1'b0);
					odata_d = {(s1_pos_q == 2'h0) ? cb_val : ((s1_pos_q == 2'h1) ? cr_hold_q : 8'h00), y_val};
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cr_hold_q        <= 8'h00;
			out_valid        <= 1'b0;
			out_sof          <= 1'b0;
			out_eol          <= 1'b0;
			out_eof          <= 1'b0;
			out_chroma_valid <= 1'b0;
			out_data         <= 16'h0000;
		end
		else
		begin
			cr_hold_q        <= cr_hold_d;
			out_valid        <= ov_d;
			out_sof          <= osof_d;
			out_eol          <= oeol_d;
			out_eof          <= oeof_d;
			out_chroma_valid <= ochr_d;
			out_data         <= odata_d;
		end
	end

	// Position of each output pixel within its line, for the checks below
	always_comb
	begin
		line_cnt_d = line_cnt_q;
		if (out_valid)
			line_cnt_d = out_eol ? '0 : line_cnt_q + XW'(1);
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			line_cnt_q <= '0;
		else
			line_cnt_q <= line_cnt_d;
	end

	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	a_ramp_step: assert property (cap_we && pipe_q && !cap_last |=> ramp_q == 8'($past(ramp_q) + 8'h01))
		else $error("ramp did not advance by one");
	a_pipe_wins: assert property (cap_we && pipe_q && sens_q |-> wr_word[39:32] == ramp_q)
		else $error("pipeline pattern not on top");
	a_real_data: assert property (cap_we && !pipe_q && !sens_q |-> wr_word[23:0] == in_rgb)
		else $error("real data altered with patterns off");
	a_select_isolates: assert property (reg_wr && reg_addr == ifrps_pkg::ADDR_PAT_CHOICE && psel_q
		|=> $stable(sens_q))
		else $error("wrong generator changed");
	a_roi_fits: assert property (int'(eff_left) + int'(eff_w) <= int'(HLIM)
		&& int'(eff_top) + int'(eff_h) <= int'(VLIM))
		else $error("region past the limits");
	a_line_length: assert property (out_valid && out_eol |-> line_cnt_q == eff_w - XW'(1))
		else $error("line length wrong");
	a_mosaic_hflip: assert property (mir_h && !mir_v |-> mosaic == ifrps_pkg::MOSAIC_GREEN_RED)
		else $error("mosaic order not updated");
	a_quarter_gap: assert property (out_valid && fmt_q == ifrps_pkg::CHROMA_QUARTER_FORMAT
		|-> out_chroma_valid == !line_cnt_q[1])
		else $error("quarter chroma grouping wrong");
	a_pad_twelve: assert property (s1_v_q && fmt_q == ifrps_pkg::FMT_MOSAIC16 && adc_q == ifrps_pkg::ADC_12
		&& !pipe_q && !sens_q |=> (out_data & ~ifrps_pkg::MASK_12) == 16'h0000)
		else $error("twelve bit padding not zero");
	a_depth_frozen: assert property (busy |=> $stable(adc_q))
		else $error("depth changed during frame");
	a_half_pairs: assert property (out_valid && fmt_q == ifrps_pkg::CHROMA_HALF_FORMAT |-> out_chroma_valid)
		else $error("half format missing chroma");

	c_pipe_frame: cover property (pipe_q && st_q == ifrps_pkg::ST_READ ##1 out_valid);
	c_half_out: cover property (out_valid && fmt_q == ifrps_pkg::CHROMA_HALF_FORMAT ##1 out_eof);
	c_both_mirror: cover property (mir_h && mir_v && out_eof);
endmodule : ifrps_top

// *** testbench/ifrps_sensor_model.sv ***
// Sensor-side model: one raster frame of W x H pixels for each go pulse.
// Assumes the stage shares clk_sys; idle data lines toggle so stale values never look valid.
module ifrps_sensor_model #(
	parameter int W = 16, // pixels per line
	parameter int H = 17  // lines per frame
) (
	input  wire logic        clk_sys,           // system clock
	input  wire logic        go,                // start one frame
	input  wire logic        slow,              // idle beat after each pixel
	output logic             in_valid = 1'h0,   // pixel valid
	output logic             in_sof = 1'h0,     // first pixel of frame
	output logic      [13:0] in_sample = 14'h0, // converter sample
	output logic      [23:0] in_rgb = 24'h0     // colour {R,G,B}
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge clk_sys)
	begin
		if (go)
		begin
			for (int y = 0; y < H; y++)
			begin
				for (int x = 0; x < W; x++)
				begin
					in_valid <= 1'h1;
					in_sof <= (x == 0 && y == 0);
					in_sample <= 14'(x * 64 + y * 2 + 1); // Fits 10 bits, so valid at every depth
					in_rgb <= (x % 2) ? 24'h0000FF : 24'hFF0000;
					@(posedge clk_sys);
					if (slow)
					begin
						in_valid <= 1'h0;
						in_sof <= 1'h0;
						in_sample <= ~in_sample;
						@(posedge clk_sys);
					end
				end
			end
			in_valid <= 1'h0;
			in_sof <= 1'h0;
		end
		else
		begin
			in_sample <= ~in_sample;
			in_rgb <= ~in_rgb;
		end
	end
endmodule : ifrps_sensor_model

// *** testbench/ifrps_bench.sv ***
// Self-checking bench for the format, pattern, mirror and region stage.
// Assumes the design carries its own assertions; the sensor model feeds the pixels.
module ifrps_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int W = 16;
	localparam int H = 17; // One line past 256 pixels, so the ramp wraps
	logic        clk_sys = 1'h0;
	logic        reset_n = 1'h0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'h0;
	logic        reg_rd = 1'h0;
	logic        go = 1'h0;
	logic        slow = 1'h0;
	logic [31:0] reg_rdata;
	logic        in_valid, in_sof, out_valid, out_sof, out_eol, out_eof, out_chroma_valid, busy;
	logic [13:0] in_sample;
	logic [23:0] in_rgb;
	logic [15:0] out_data;
	int          num_errors = 0;
	int          checks_done = 0;
	int          md = 0, mh = 0, mv = 0, lx = 0, ty = 0, rw = W, rh = H;
	ifrps_sensor_model #(.W(W), .H(H)) sensor (.clk_sys, .go, .slow, .in_valid, .in_sof, .in_sample, .in_rgb);
	ifrps_top #(.MAX_W(W), .MAX_H(H), .ADC_W(14)) uut (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .in_valid, .in_sof, .in_sample, .in_rgb, .out_valid, .out_sof, .out_eol, .out_eof,
		.out_data, .out_chroma_valid, .busy);
	initial
		forever #20 clk_sys = ~clk_sys;
	task automatic check(logic [31:0] got, logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(logic [7:0] a, logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
		@(posedge clk_sys);
	endtask : wr
	task automatic rd(logic [7:0] a, logic [31:0] exp);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		@(negedge clk_sys);
		check(reg_rdata, exp);
		@(posedge clk_sys);
	endtask : rd
	// Expected {chroma_valid, data} at output position; source found through mirror, then crop
	function automatic logic [16:0] pix(int ox, int oy);
		int sx, sy, s;
		sx = mh ? W - 1 - (lx + ox) : lx + ox;
		sy = mv ? H - 1 - (ty + oy) : ty + oy;
		s = sx * 64 + sy * 2 + 1;
		case (md)
			0: return {9'h000, 8'(sy * W + sx)};
			1: return 17'(s << 4);
			2: return 17'(s << 6);
			3: return 17'(s >> 6);
			default: return (md == 5 && ox % 4 > 1) ? {9'h000, ox[0] ? 8'h1D : 8'h4D}
				: {1'h1, ox[0] ? 16'hFF1D : 16'h554D};
		endcase
	endfunction : pix
	task automatic run_frame;
		int k;
		k = 0;
		wr(ifrps_pkg::ADDR_FORMAT, (md == 0 || md == 3) ? 0 : (md < 3 ? 1 : md - 2));
		wr(ifrps_pkg::ADDR_ADC_DEPTH, md == 2 ? 0 : (md == 3 ? 2 : 1));
		wr(ifrps_pkg::ADDR_ROI_LEFT, lx);
		wr(ifrps_pkg::ADDR_ROI_TOP, ty);
		wr(ifrps_pkg::ADDR_ROI_WIDTH, rw);
		wr(ifrps_pkg::ADDR_ROI_HEIGHT, rh);
		wr(ifrps_pkg::ADDR_CTRL, {mv[0], mh[0], 1'h1});
		go <= 1'h1;
		@(posedge clk_sys);
		go <= 1'h0;
		for (int n = 0; n < 5000 && k < rw * rh; n++)
		begin
			@(negedge clk_sys);
			if (out_valid === 1'h1)
			begin
				check({out_sof, out_eol, out_eof, out_chroma_valid, out_data},
					{k == 0, k % rw == rw - 1, k == rw * rh - 1, pix(k % rw, k / rw)});
				k++;
			end
		end
		check(k, rw * rh);
		check(busy, 1'h0);
		@(posedge clk_sys);
	endtask : run_frame
	task automatic t_regs;
		rd(ifrps_pkg::ADDR_FORMAT, 0);
		rd(ifrps_pkg::ADDR_ADC_DEPTH, 1);
		rd(ifrps_pkg::ADDR_ROI_WIDTH, W);
		rd(ifrps_pkg::ADDR_ROI_HEIGHT, H);
		wr(ifrps_pkg::ADDR_HLIMIT, 3);
		rd(ifrps_pkg::ADDR_HLIMIT, W);
		rd(ifrps_pkg::ADDR_VLIMIT, H);
		rd(8'h3C, 0);
		wr(ifrps_pkg::ADDR_ADC_DEPTH, 3);
		rd(ifrps_pkg::ADDR_ADC_DEPTH, 1);
		wr(ifrps_pkg::ADDR_ROI_LEFT, 5);
		rd(ifrps_pkg::ADDR_WIDTH_MAX, W - 5);
		rd(ifrps_pkg::ADDR_ROI_WIDTH, W - 5);
		wr(ifrps_pkg::ADDR_ROI_TOP, 3);
		rd(ifrps_pkg::ADDR_HEIGHT_MAX, H - 3);
		wr(ifrps_pkg::ADDR_ROI_HEIGHT, 99);
		rd(ifrps_pkg::ADDR_ROI_HEIGHT, H - 3);
	endtask : t_regs
	task automatic t_patterns;
		wr(ifrps_pkg::ADDR_PAT_SOURCE, 0);
		wr(ifrps_pkg::ADDR_PAT_CHOICE, 1);
		rd(ifrps_pkg::ADDR_STATUS, 32'h2);
		wr(ifrps_pkg::ADDR_PAT_SOURCE, 1);
		wr(ifrps_pkg::ADDR_PAT_CHOICE, 1);
		rd(ifrps_pkg::ADDR_STATUS, 32'h6);
		md = 0;
		wr(ifrps_pkg::ADDR_BLACK, 32'h0000_0100); // Black level must not touch patterns
		run_frame();
		wr(ifrps_pkg::ADDR_BLACK, 32'h0000_0000);
		wr(ifrps_pkg::ADDR_PAT_CHOICE, 0);
		rd(ifrps_pkg::ADDR_STATUS, 32'h2);
		wr(ifrps_pkg::ADDR_PAT_SOURCE, 0);
		wr(ifrps_pkg::ADDR_PAT_CHOICE, 0);
		rd(ifrps_pkg::ADDR_STATUS, 32'h0);
	endtask : t_patterns
	task automatic t_formats;
		for (md = 1; md < 6; md++)
			run_frame();
	endtask : t_formats
	task automatic t_mirror;
		md = 1;
		slow = 1'h1;
		lx = 2;
		ty = 3;
		rw = 5;
		rh = 4;
		mh = 1;
		run_frame();
		rd(ifrps_pkg::ADDR_STATUS, 32'h10);
		mh = 0;
		mv = 1;
		run_frame();
		rd(ifrps_pkg::ADDR_STATUS, 32'h20);
	endtask : t_mirror
	task automatic wrap_up;
		$display("checks %0d, errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	initial
	begin
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'h1;
		t_regs();
		t_patterns();
		t_formats();
		t_mirror();
		wrap_up();
	end
	// Roughly five times the expected run of about 5000 cycles
	initial
	begin
		#1000000;
		num_errors++;
		wrap_up();
	end
endmodule : ifrps_bench
